// >>> rtl/hsrx_pkg.sv
/*
  Shared constants, types and helpers of the serial receive control block.
  Assumes a single 20 MHz clock domain and a classic Wishbone register bus.
*/
package hsrx_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SWEEP_STEP_NS = 800;
  localparam int SWEEP_STEP_CYC = (SWEEP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SWEEP_CNT_W = 5;
  localparam logic [SWEEP_CNT_W-1:0] SWEEP_LAST = SWEEP_CNT_W'(SWEEP_STEP_CYC - 1);

  // ----------------------------------------
  // deserializer
  // ----------------------------------------
  localparam int WORD_W = 20;
  localparam int SLOT_W = 5;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 5'h13;
  localparam logic [SLOT_W-1:0] SLOT_HIGH_LAST = 5'h09;

  // ----------------------------------------
  // frequency integrator and phase filter
  // ----------------------------------------
  localparam int INTEG_W = 12;
  localparam logic [INTEG_W-1:0] INTEG_MAX = 12'hFFF;
  localparam logic [INTEG_W-1:0] INTEG_MIN = 12'h000;
  localparam logic [INTEG_W-1:0] INTEG_RST = 12'h800;
  localparam int FILT_W = 16;
  localparam int FILT_SHIFT = 4;
  localparam logic [FILT_W-1:0] FILT_ONE = 16'hFFFF;
  localparam logic [FILT_W-1:0] FILT_RST = 16'h8000;
  localparam logic [FILT_W-1:0] PL_THRESH = 16'hA8F6;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam int LANE0 = 0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_INTEG = 8'h10;
  localparam int CTRL_W = 2;
  localparam int CTRL_FORCE_MUTE = 0;
  localparam int CTRL_SWEEP_EN = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h2;
  localparam int IRQ_W = 4;
  localparam int IRQ_LOCK_ON = 0;
  localparam int IRQ_LOCK_OFF = 1;
  localparam int IRQ_CARRIER = 2;
  localparam int IRQ_MUTE = 3;
  localparam int ST_W = 6;
  localparam int ST_LOCK = 0;
  localparam int ST_PHASE = 1;
  localparam int ST_NODATA = 2;
  localparam int ST_CARRIER = 3;
  localparam int ST_MUTE = 4;
  localparam int ST_SWEEP_DOWN = 5;

  typedef enum logic {SWEEP_UP, SWEEP_DOWN} hsrx_dir_e;

  function automatic logic [INTEG_W-1:0] hsrx_integ_step(input logic [INTEG_W-1:0] v,
                                                         input logic up);
    if (up)
      return (v == INTEG_MAX) ? v : v + 1'b1;
    else
      return (v == INTEG_MIN) ? v : v - 1'b1;
  endfunction

endpackage

// >>> rtl/hsrx_if.sv
/*
  Carriers between the top and its loop-control and deserializer modules.
  Assumes all ends run on the same clock.
*/
`timescale 1ns/1ns
interface hsrx_lock_if import hsrx_pkg::*; ();
  logic pump_up;
  logic pump_dn;
  logic quad_sample;
  logic quad_valid;
  logic sweep_en;
  logic [INTEG_W-1:0] integ;
  logic phase_lock;
  logic no_data;
  logic lock;
  logic sweep_down;
  modport loop (input pump_up, pump_dn, quad_sample, quad_valid, sweep_en,
                output integ, phase_lock, no_data, lock, sweep_down);
  modport ctl (output pump_up, pump_dn, quad_sample, quad_valid, sweep_en,
               input integ, phase_lock, no_data, lock, sweep_down);
endinterface

interface hsrx_deser_if import hsrx_pkg::*; ();
  logic bit_in;
  logic [WORD_W-1:0] word;
  logic word_strobe;
  logic pclk;
  modport conv (input bit_in, output word, word_strobe, pclk);
  modport ctl (output bit_in, input word, word_strobe, pclk);
endinterface

// >>> rtl/hsrx_lock_loop.sv
/*
  Frequency integrator, acquisition sweep and phase-lock filter.
  Assumes pump pulses and quadrature samples are synchronous to clk.
*/
`timescale 1ns/1ns
module hsrx_lock_loop import hsrx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  hsrx_lock_if.loop lk
);

  typedef struct packed {
    logic [INTEG_W-1:0] integ;
    hsrx_dir_e dir;
    logic [FILT_W-1:0] filt;
    logic phase_lock;
    logic [SWEEP_CNT_W-1:0] cnt;
  } hsrx_loop_s;

  hsrx_loop_s s_reg;
  hsrx_loop_s s_next;

  always_comb
  begin
    s_next = s_reg;
    // first-order low pass of the quadrature sample
    if (lk.quad_valid)
      s_next.filt = s_reg.filt - (s_reg.filt >> FILT_SHIFT)
                    + (lk.quad_sample ? (FILT_ONE >> FILT_SHIFT) : '0);
    s_next.phase_lock = s_reg.filt > PL_THRESH; // R17
    if (lk.pump_up ^ lk.pump_dn)
      s_next.integ = hsrx_integ_step(s_reg.integ, lk.pump_up);
    if (!s_reg.phase_lock && lk.sweep_en) // R4
    begin
      s_next.cnt = (s_reg.cnt == SWEEP_LAST) ? '0 : s_reg.cnt + 1'b1;
      if (s_reg.cnt == SWEEP_LAST)
        s_next.integ = hsrx_integ_step(s_next.integ, s_reg.dir == SWEEP_UP); // R3
    end
    else
      s_next.cnt = '0;
    if (s_reg.integ == INTEG_MAX) // R5
      s_next.dir = SWEEP_DOWN;
    else if (s_reg.integ == INTEG_MIN)
      s_next.dir = SWEEP_UP;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_reg <= '{integ: INTEG_RST, dir: SWEEP_UP, filt: FILT_RST, phase_lock: 1'b0, cnt: '0};
    else if (ce)
      s_reg <= s_next;
  end

  assign lk.integ = s_reg.integ;
  assign lk.phase_lock = s_reg.phase_lock;
  assign lk.no_data = (s_reg.integ == INTEG_MAX) || (s_reg.integ == INTEG_MIN); // R2
  assign lk.lock = !lk.no_data && s_reg.phase_lock;
  assign lk.sweep_down = (s_reg.dir == SWEEP_DOWN);

  sweep_stop_a: assert property (@(posedge clk) disable iff (!rstn) // R4
    ce && s_reg.phase_lock && !(lk.pump_up ^ lk.pump_dn) |=> $stable(s_reg.integ))
    else $error("integrator moved while phase locked");
  sweep_step_a: assert property (@(posedge clk) disable iff (!rstn) // R3
    ce && !s_reg.phase_lock && lk.sweep_en && s_reg.cnt == SWEEP_LAST
    && !(lk.pump_up ^ lk.pump_dn) && !lk.no_data |=> !$stable(s_reg.integ))
    else $error("sweep step missing");
  sweep_reverse_a: assert property (@(posedge clk) disable iff (!rstn) // R5
    ce && s_reg.integ == INTEG_MAX |=> s_reg.dir == SWEEP_DOWN)
    else $error("sweep did not reverse at top end");

endmodule

// >>> rtl/hsrx_deser.sv
/*
  1:20 serial to parallel converter with a freewheeling divided clock.
  Assumes one serial bit per clk; no word alignment is attempted.
*/
`timescale 1ns/1ns
module hsrx_deser import hsrx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  hsrx_deser_if.conv dz
);

  typedef struct packed {
    logic [WORD_W-1:0] shreg;
    logic [SLOT_W-1:0] slot;
    logic [WORD_W-1:0] word;
    logic strobe;
    logic pclk;
  } hsrx_deser_s;

  hsrx_deser_s s_reg;
  hsrx_deser_s s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.shreg = {s_reg.shreg[WORD_W-2:0], dz.bit_in}; // R13
    // slot counter never looks at lock, so the divided clock keeps running
    s_next.slot = (s_reg.slot == SLOT_LAST) ? '0 : s_reg.slot + 1'b1; // R16
    s_next.strobe = (s_reg.slot == SLOT_LAST);
    if (s_reg.slot == SLOT_LAST) // R18
      s_next.word = {s_reg.shreg[WORD_W-2:0], dz.bit_in}; // R14
    s_next.pclk = (s_next.slot <= SLOT_HIGH_LAST); // R15
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_reg <= '0;
    else if (ce)
      s_reg <= s_next;
  end

  assign dz.word = s_reg.word;
  assign dz.word_strobe = s_reg.strobe;
  assign dz.pclk = s_reg.pclk;

  word_slot_a: assert property (@(posedge clk) disable iff (!rstn) // R18
    ce && s_reg.slot == SLOT_LAST |=> s_reg.strobe
    && s_reg.word == $past({s_reg.shreg[WORD_W-2:0], dz.bit_in}))
    else $error("word not captured at end of slot");
  pclk_low_a: assert property (@(posedge clk) disable iff (!rstn) // R15
    ce && s_reg.slot == SLOT_HIGH_LAST |=> !s_reg.pclk)
    else $error("parallel clock high half too long");

endmodule

// >>> rtl/hsrx_top.sv
/*
  Control and deserializing logic of an HD serial video receiver: lock
  logic, input select, reclock bypass, mute, carrier flag, 1:20 converter,
  Wishbone register slave and interrupt.
  Assumes all pins synchronous to clk; the serial bit rate equals clk.
*/
// Local design decisions: the register addresses and the Wishbone register port.
// Operation
// [R1] lock low when no data or no phase lock
// [R2] saturated integrator means data absent
// [R3] sweep the integrator while acquiring
// [R4] stop sweeping once phase lock is set
// [R5] reverse sweep at either saturation end
// [R6] bypass low routes around reclock and mute
// [R7] mute ignored while bypass selected
// [R8] loop and lock report still work in bypass
// [R9] driver enable low turns serial driver on
// [R10] select high takes analog, low digital input
// [R11] carrier flag low while carrier present
// [R12] mute below level unless level adjust open
// [R13] shift serial bits into 20-bit words
// [R14] words leave unaligned and not descrambled
// [R15] parallel clock is serial rate over twenty
// [R16] parallel clock freewheels when lock lost
// [R17] phase lock when filtered sample exceeds 0.66
// [R18] one new word per parallel clock cycle
`timescale 1ns/1ns
module hsrx_top import hsrx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [SEL_W-1:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic analog_data_in,
  input wire logic digital_data_in,
  input wire logic source_select,
  input wire logic bypass_n,
  input wire logic quad_sample,
  input wire logic quad_valid,
  input wire logic pump_up,
  input wire logic pump_dn,
  input wire logic carrier_sense,
  input wire logic signal_below_level,
  input wire logic mute_level_adjust,
  input wire logic serial_out_driver_enable_n,
  output logic pll_lock,
  output logic carrier_present_n,
  output logic serial_out_pair,
  output logic serial_out_oe,
  output logic [WORD_W-1:0] par_data,
  output logic par_clk,
  output logic par_strobe
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic ack;
    logic [DATA_W-1:0] dat_o;
    logic irq;
    logic reclk_bit;
    logic lock;
    logic carrier_n;
    logic mute;
    logic ser_out;
    logic ser_oe;
    logic [WORD_W-1:0] par_data;
    logic par_clk;
    logic par_strobe;
  } hsrx_top_s;

  hsrx_top_s s_reg;
  hsrx_top_s s_next;

  hsrx_lock_if lk();
  hsrx_deser_if dz();

  logic in_bit;
  logic mute_now;
  logic wb_hit;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] irq_clr;
  logic [ST_W-1:0] status;
  logic [DATA_W-1:0] rd_data;

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  hsrx_lock_loop u_loop (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .lk(lk)
  );

  hsrx_deser u_deser (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .dz(dz)
  );

  // the loop sees its pins in bypass too, so lock is still reported
  assign lk.pump_up = pump_up; // R8
  assign lk.pump_dn = pump_dn;
  assign lk.quad_sample = quad_sample;
  assign lk.quad_valid = quad_valid;
  assign lk.sweep_en = s_reg.ctrl[CTRL_SWEEP_EN];

  // ----------------------------------------
  // data path
  // ----------------------------------------
  assign in_bit = source_select ? analog_data_in : digital_data_in; // R10
  // bypass skips the reclock stage, trading retiming for one less cycle
  assign dz.bit_in = bypass_n ? s_reg.reclk_bit : in_bit; // R6
  // an open level-adjust pin reads low and disables the below-level mute
  assign mute_now = bypass_n && ((signal_below_level && mute_level_adjust) // R12
                    || s_reg.ctrl[CTRL_FORCE_MUTE]); // R7

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  assign wb_hit = wb_cyc_i && wb_stb_i && !s_reg.ack;

  always_comb
  begin
    status = '0;
    status[ST_LOCK] = s_reg.lock;
    status[ST_PHASE] = lk.phase_lock;
    status[ST_NODATA] = lk.no_data;
    status[ST_CARRIER] = !s_reg.carrier_n;
    status[ST_MUTE] = s_reg.mute;
    status[ST_SWEEP_DOWN] = lk.sweep_down;
  end

  always_comb
  begin
    unique case (wb_adr_i)
      ADDR_CTRL: rd_data = DATA_W'(s_reg.ctrl);
      ADDR_STATUS: rd_data = DATA_W'(status);
      ADDR_IRQ_STAT: rd_data = DATA_W'(s_reg.irq_stat);
      ADDR_IRQ_MASK: rd_data = DATA_W'(s_reg.irq_mask);
      ADDR_INTEG: rd_data = DATA_W'(lk.integ);
      default: rd_data = '0;
    endcase
  end

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  always_comb
  begin
    events = '0;
    events[IRQ_LOCK_ON] = lk.lock && !s_reg.lock;
    events[IRQ_LOCK_OFF] = !lk.lock && s_reg.lock;
    events[IRQ_CARRIER] = (!carrier_sense) != s_reg.carrier_n;
    events[IRQ_MUTE] = mute_now && !s_reg.mute;
    irq_clr = '0;
    if (wb_hit && wb_we_i && wb_sel_i[LANE0] && wb_adr_i == ADDR_IRQ_STAT)
      irq_clr = wb_dat_i[IRQ_W-1:0];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.ack = wb_hit;
    if (wb_hit)
      s_next.dat_o = wb_we_i ? '0 : rd_data;
    if (wb_hit && wb_we_i && wb_sel_i[LANE0])
    begin
      if (wb_adr_i == ADDR_CTRL)
        s_next.ctrl = wb_dat_i[CTRL_W-1:0];
      if (wb_adr_i == ADDR_IRQ_MASK)
        s_next.irq_mask = wb_dat_i[IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    s_next.irq_stat = (s_reg.irq_stat & ~irq_clr) | events;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    s_next.reclk_bit = in_bit;
    s_next.lock = lk.lock; // R1
    s_next.carrier_n = !carrier_sense; // R11
    s_next.mute = mute_now;
    s_next.ser_out = bypass_n ? (s_reg.reclk_bit && !mute_now) : in_bit; // R6
    // the driver enable pin is active low, so the output enable is its inverse
    s_next.ser_oe = !serial_out_driver_enable_n; // R9
    s_next.par_clk = dz.pclk; // R15
    s_next.par_strobe = dz.word_strobe;
    if (dz.word_strobe) // R18
      s_next.par_data = mute_now ? '0 : dz.word; // R12
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.carrier_n <= 1'b1;
    end
    else if (ce)
      s_reg <= s_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_dat_o = s_reg.dat_o;
  assign wb_ack_o = s_reg.ack;
  assign irq = s_reg.irq;
  assign pll_lock = s_reg.lock;
  assign carrier_present_n = s_reg.carrier_n;
  assign serial_out_pair = s_reg.ser_out;
  assign serial_out_oe = s_reg.ser_oe;
  assign par_data = s_reg.par_data;
  assign par_clk = s_reg.par_clk;
  assign par_strobe = s_reg.par_strobe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  lock_low_a: assert property (@(posedge clk) disable iff (!rstn) // R1
    ce && (lk.no_data || !lk.phase_lock) |=> !pll_lock)
    else $error("lock high without data or phase lock");
  bypass_lock_a: assert property (@(posedge clk) disable iff (!rstn) // R8
    ce && !bypass_n && lk.lock |=> pll_lock)
    else $error("lock not reported in bypass");
  bypass_nomute_a: assert property (@(posedge clk) disable iff (!rstn) // R7
    ce && !bypass_n && dz.word_strobe |=> par_data == $past(dz.word))
    else $error("parallel word muted in bypass");
  mute_word_a: assert property (@(posedge clk) disable iff (!rstn) // R12
    ce && bypass_n && signal_below_level && mute_level_adjust && dz.word_strobe
    |=> par_data == '0)
    else $error("word not muted below level");
  source_sel_a: assert property (@(posedge clk) disable iff (!rstn) // R10
    ce && bypass_n && !source_select ##1 ce && bypass_n
    |=> serial_out_pair == ($past(digital_data_in, 2) && !$past(mute_now)))
    else $error("serial out does not follow digital input");
  carrier_flag_a: assert property (@(posedge clk) disable iff (!rstn) // R11
    ce |=> carrier_present_n == !$past(carrier_sense))
    else $error("carrier flag wrong level");
  driver_en_a: assert property (@(posedge clk) disable iff (!rstn) // R9
    ce |=> serial_out_oe != $past(serial_out_driver_enable_n))
    else $error("serial driver enable inverted");
  wb_ack_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o || !ce)
    else $error("ack not a single cycle");

endmodule

// >>> testbench/hsrx_deformatter_model.sv
/*
  Stand-in for the downstream deformatter: takes each parallel word as
  delivered and checks the strobe and divided-clock cadence.
  Assumes the block's clk and rstn, with ce held high.
*/
`timescale 1ns/1ns
module hsrx_deformatter_model import hsrx_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WORD_W-1:0] par_data,
  input wire logic par_clk,
  input wire logic par_strobe,
  output logic [WORD_W-1:0] word_q,
  output int words,
  output int cadence_err
);
  int gap;
  int high_run;
  // ----------------------------------------
  // capture and cadence
  // ----------------------------------------
  // framing and descrambling would start here; words are kept as delivered
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gap <= 0;
      high_run <= 0;
      words <= 0;
      word_q <= '0;
      cadence_err <= 0;
    end
    else
    begin
      gap <= (par_strobe === 1'b1) ? 1 : gap + 1;
      high_run <= (par_clk === 1'b1) ? high_run + 1 : 0;
      if (par_strobe === 1'b1)
      begin
        word_q <= par_data;
        words <= words + 1;
      end
      cadence_err <= cadence_err
        + int'(par_strobe === 1'b1 && words > 0 && gap != 20)
        + int'(par_strobe === 1'b1 && par_clk !== 1'b1)
        + int'(par_clk === 1'b0 && words > 0 && high_run != 0 && high_run != 10);
    end
  end
endmodule

// >>> testbench/hd_serial_rx_lock_deser_tb_top.sv
/*
  Self-checking bench of the receive control block: lock, sweep, select,
  bypass, mute, carrier, interrupt and the 1:20 converter.
  Assumes one 20 MHz clock; registers reached over classic Wishbone.
*/
`timescale 1ns/1ns
module hd_serial_rx_lock_deser_tb_top import hsrx_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [DATA_W-1:0] wb_dat_i = '0, wb_dat_o;
  logic [SEL_W-1:0] wb_sel_i = '0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, irq;
  logic analog_data_in = 1'b0, digital_data_in = 1'b0, source_select = 1'b0;
  logic bypass_n = 1'b1, quad_sample = 1'b0, quad_valid = 1'b0;
  logic pump_up = 1'b0, pump_dn = 1'b0, carrier_sense = 1'b0;
  logic signal_below_level = 1'b0, mute_level_adjust = 1'b0;
  logic serial_out_driver_enable_n = 1'b1;
  logic pll_lock, carrier_present_n, serial_out_pair, serial_out_oe, par_clk, par_strobe;
  logic [WORD_W-1:0] par_data, word_q;
  logic [15:0] lfsr = 16'hACE1;
  logic ones = 1'b0;
  logic [63:0] hist = '0;
  int err_count = 0, checks = 0, words, cadence_err;

  hsrx_top dut (.clk, .rstn, .ce, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .irq, .analog_data_in, .digital_data_in,
    .source_select, .bypass_n, .quad_sample, .quad_valid, .pump_up, .pump_dn,
    .carrier_sense, .signal_below_level, .mute_level_adjust, .serial_out_driver_enable_n,
    .pll_lock, .carrier_present_n, .serial_out_pair, .serial_out_oe, .par_data, .par_clk,
    .par_strobe);
  hsrx_deformatter_model far_end (.clk, .rstn, .par_data, .par_clk, .par_strobe,
    .word_q, .words, .cadence_err);

  initial forever #25 clk = ~clk;

  // while ones is low, analog and digital carry opposite bits so a wrong select cannot match
  always @(posedge clk)
  begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    analog_data_in <= ones | lfsr[0];
    digital_data_in <= ~lfsr[0];
    hist <= {hist[62:0], source_select ? (ones | lfsr[0]) : ~lfsr[0]};
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic timeout(input string what);
    err_count++;
    $display("wrong value at %0t: timeout %s", $time, what);
    close_out();
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ack and read data taken at the rising edge, request still standing
  task automatic wb(input logic [ADDR_W-1:0] adr, input logic we,
                    input logic [DATA_W-1:0] dat, output logic [DATA_W-1:0] rd);
    int n;
    @(posedge clk);
    wb_adr_i <= adr;
    wb_we_i <= we;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (wb_ack_o === 1'b1)
        break;
    end
    if (n == 20)
      timeout("bus");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] adr, input logic [DATA_W-1:0] dat);
    logic [DATA_W-1:0] junk;
    wb(adr, 1'b1, dat, junk);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] adr, input logic [DATA_W-1:0] m, e);
    logic [DATA_W-1:0] r;
    wb(adr, 1'b0, 32'h0, r);
    chk(r & m, e, "register");
  endtask

  task automatic wait_strobe();
    int n;
    for (n = 0; n < 30; n++)
    begin
      @(posedge clk);
      if (par_strobe === 1'b1)
        break;
    end
    if (n == 30)
      timeout("strobe");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(pll_lock, 32'h0, "lock at reset");
    chk(carrier_present_n, 32'h1, "no carrier");
    rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h2);
    rd_chk(ADDR_INTEG, 32'hFFFFFFFF, 32'h800);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_stream(input logic sel, input logic byp_n, output int d);
    @(posedge clk);
    source_select <= sel;
    bypass_n <= byp_n;
    repeat (3) wait_strobe();
    d = -1;
    for (int k = 0; k < 8; k++)
      if (d < 0 && par_data === hist[k +: 20])
        d = k;
    chk(d >= 0, 32'h1, "word found");
    repeat (3)
    begin
      wait_strobe();
      chk(par_data, hist[d +: 20], "word");
    end
    $display("test stream sel %0b bypass_n %0b done", sel, byp_n);
  endtask

  task automatic t_mute();
    // bypass_n, below level, level adjust connected, forced mute
    logic [3:0] rows [6] = '{4'b1110, 4'b1100, 4'b0110, 4'b1000, 4'b1001, 4'b0001};
    logic muted;
    @(posedge clk);
    ones <= 1'b1;
    source_select <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_CTRL, {30'h0, 1'b1, rows[i][0]});
      @(posedge clk);
      bypass_n <= rows[i][3];
      signal_below_level <= rows[i][2];
      mute_level_adjust <= rows[i][1];
      repeat (3) wait_strobe();
      muted = rows[i][3] & (rows[i][0] | (rows[i][2] & rows[i][1]));
      chk(par_data, muted ? 20'h0 : 20'hFFFFF, "mute");
      chk(serial_out_pair, muted ? 32'h0 : 32'h1, "serial out");
    end
    wr(ADDR_CTRL, 32'h2);
    ones <= 1'b0;
    signal_below_level <= 1'b0;
    $display("test mute done");
  endtask

  task automatic t_carrier();
    wr(ADDR_IRQ_STAT, 32'hF);
    wr(ADDR_IRQ_MASK, 32'h4);
    @(posedge clk);
    carrier_sense <= 1'b1;
    cycles(3);
    chk(carrier_present_n, 32'h0, "carrier");
    rd_chk(ADDR_STATUS, 32'h8, 32'h8);
    chk(irq, 32'h1, "irq raised");
    wr(ADDR_IRQ_STAT, 32'h4);
    cycles(2);
    chk(irq, 32'h0, "irq cleared");
    wr(ADDR_IRQ_MASK, 32'h0);
    carrier_sense <= 1'b0;
    cycles(3);
    chk(carrier_present_n, 32'h1, "carrier gone");
    rd_chk(ADDR_IRQ_STAT, 32'h4, 32'h4);
    chk(irq, 32'h0, "irq masked");
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
    @(posedge clk);
    serial_out_driver_enable_n <= 1'b0;
    cycles(2);
    chk(serial_out_oe, 32'h1, "driver on");
    serial_out_driver_enable_n <= 1'b1;
    cycles(2);
    chk(serial_out_oe, 32'h0, "driver off");
    $display("test carrier done");
  endtask

  task automatic t_lock();
    logic [DATA_W-1:0] a;
    int n;
    wb(ADDR_INTEG, 1'b0, 32'h0, a);
    chk(a != 32'h800, 32'h1, "sweep moved");
    @(posedge clk);
    bypass_n <= 1'b0;
    quad_sample <= 1'b1;
    quad_valid <= 1'b1;
    cycles(60);
    chk(pll_lock, 32'h1, "locked");
    rd_chk(ADDR_STATUS, 32'h7, 32'h3);
    wb(ADDR_INTEG, 1'b0, 32'h0, a);
    cycles(64);
    rd_chk(ADDR_INTEG, 32'hFFF, a);
    @(posedge clk);
    pump_up <= 1'b1;
    repeat (3) @(posedge clk);
    pump_up <= 1'b0;
    cycles(2);
    rd_chk(ADDR_INTEG, 32'hFFF, a + 32'h3);
    pump_dn <= 1'b1;
    for (n = 0; n < 3000; n++)
    begin
      @(posedge clk);
      if (pll_lock === 1'b0)
        break;
    end
    if (n == 3000)
      timeout("no data");
    rd_chk(ADDR_STATUS, 32'h7, 32'h6);
    pump_dn <= 1'b0;
    rd_chk(ADDR_INTEG, 32'hFFF, 32'h0);
    quad_sample <= 1'b0;
    cycles(300);
    rd_chk(ADDR_STATUS, 32'h26, 32'h0);
    wb(ADDR_INTEG, 1'b0, 32'h0, a);
    chk(a > 32'h0 && a < 32'h20, 32'h1, "swept up");
    // drive to the top end so the sweep must turn round there
    pump_up <= 1'b1;
    cycles(4200);
    pump_up <= 1'b0;
    cycles(40);
    rd_chk(ADDR_STATUS, 32'h24, 32'h20);
    repeat (3) wait_strobe();
    $display("test lock done");
  endtask

  initial
  begin
    int d0, d1, d2;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_stream(1'b0, 1'b0, d0);
    t_stream(1'b1, 1'b0, d1);
    chk(d1, d0, "select offset");
    t_stream(1'b1, 1'b1, d2);
    chk(d2, d0 + 1, "reclock offset");
    t_mute();
    t_carrier();
    t_lock();
    chk(cadence_err, 32'h0, "cadence");
    chk(words > 40, 32'h1, "words taken");
    close_out();
  end
endmodule
